// *** logic/gwt_guard_timer.sv ***
/*
 guard timer: 16-bit reloadable down-counter ticked by the rc oscillator pin.
 assumes: rc_osc_i is an asynchronous square wave far slower than core_clk_i;
 cpu strobes are one-cycle pulses on core_clk_i; srst_i is power-on reset.
*/
//
// Operation
// R1: counter advances only on synchronised rising edges of the rc oscillator pin
// R2: once running it counts continuously until timeout or refresh
// R3: refresh instruction starts the timer if it is stopped
// R4: always-on option keeps the timer running without any refresh
// R5: oscillator enable low stops all counting
// R6: 16-bit down-counter, reload is high byte above low byte
// R7: timeout in milliseconds equals reload divided by ten at typical rate
// R8: reload resets to 0400 hex
// R9: any 16-bit reload up to FFFF hex is accepted
// R10: first enable loads counter with reload before counting
// R11: counter decrements, reaching zero is a timeout unless refreshed
// R12: refresh reloads counter and counting resumes at once
// R13: debugger active keeps refreshing so no timeout occurs
// R14: timeout answer selectable between short reset and exception
// R15: exception answer requests exception, reloads and keeps counting
// R16: reset answer pulses device reset and sets the reset status flag
// R17: software writes 55 then AA to high, then high then low bytes
// R18: reads of the reload addresses return the live counter
// R19: oscillator edges cross into core clock without loss or duplication
`timescale 1ns/1ps
`default_nettype none
module gwt_guard_timer (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic rc_osc_i,
   input wire logic guard_osc_enable_i,
   input wire logic always_on_option_i,
   input wire logic timeout_response_option_i,
   input wire logic on_chip_debugger_i,
   input wire logic refresh_i,
   input wire logic wr_high_i,
   input wire logic wr_low_i,
   input wire logic [7:0] wr_data_i,
   input wire logic reset_flag_clear_i,
   output logic [7:0] reload_high_byte_o,
   output logic [7:0] reload_low_byte_o,
   output logic [15:0] reload_o,
   output logic running_o,
   output logic exception_req_o,
   output logic device_reset_o,
   output logic reset_flag_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      gwt_pkg::gwt_unlock_t unlock;
      logic [15:0] reload;
      logic [15:0] count;
      logic running;
      logic exc_req;
      logic [2:0] rst_cnt;
      logic flag;
   } gwt_state_t;
   gwt_state_t s_q;
   gwt_state_t s_d;

   logic osc_rise;
   logic tick;
   logic start;
   logic load;
   logic timeout;

   // ----------------------------------------
   // oscillator crossing
   // ----------------------------------------
   gwt_sync_rise u_sync ( // R19
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .async_i(rc_osc_i),
      .rise_o(osc_rise)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      tick = osc_rise & guard_osc_enable_i; // R1 R5
      start = ~s_q.running & (refresh_i | always_on_option_i); // R3 R4
      load = start | (s_q.running & (refresh_i | on_chip_debugger_i)); // R10 R12 R13
      timeout = s_q.running & tick & ~load & (s_q.count <= gwt_pkg::CNT_ONE); // R11
      s_d.exc_req = 1'b0;
      if (s_q.rst_cnt != gwt_pkg::RST_CNT_ZERO) begin
         s_d.rst_cnt = s_q.rst_cnt - 3'h1;
      end
      // unlock sequence and reload writes
      case (s_q.unlock)
         gwt_pkg::GWT_LOCKED: begin
            if (wr_high_i && wr_data_i == gwt_pkg::UNLOCK_1) begin
               s_d.unlock = gwt_pkg::GWT_GOT_FIRST;
            end
         end
         gwt_pkg::GWT_GOT_FIRST: begin
            if (wr_high_i) begin
               s_d.unlock = (wr_data_i == gwt_pkg::UNLOCK_2) ?
                  gwt_pkg::GWT_OPEN_HIGH : gwt_pkg::GWT_LOCKED;
            end
         end
         gwt_pkg::GWT_OPEN_HIGH: begin
            if (wr_high_i) begin
               s_d.reload[15:8] = wr_data_i; // R6 R9
               s_d.unlock = gwt_pkg::GWT_OPEN_LOW;
            end
         end
         gwt_pkg::GWT_OPEN_LOW: begin
            if (wr_low_i) begin
               s_d.reload[7:0] = wr_data_i; // R6 R9
               s_d.unlock = gwt_pkg::GWT_LOCKED;
            end
         end
         default: begin
            s_d.unlock = gwt_pkg::GWT_LOCKED;
         end
      endcase
      // counter
      if (start) begin
         s_d.running = 1'b1; // R2 R3 R4
      end
      if (load) begin
         s_d.count = s_q.reload; // R10 R12 R13
      end else if (timeout) begin
         if (timeout_response_option_i) begin
            s_d.rst_cnt = gwt_pkg::RST_PULSE_CYC; // R14 R16
            s_d.flag = 1'b1; // R16
            s_d.reload = gwt_pkg::RELOAD_RST;
            s_d.count = gwt_pkg::RELOAD_RST;
            s_d.running = always_on_option_i;
            s_d.unlock = gwt_pkg::GWT_LOCKED;
         end else begin
            s_d.exc_req = 1'b1; // R14 R15
            s_d.count = s_q.reload; // R15
         end
      end else if (s_q.running && tick) begin
         s_d.count = s_q.count - gwt_pkg::CNT_ONE; // R2 R7 R11
      end
      // status flag, a set in the same cycle beats the clear
      if (reset_flag_clear_i && !(timeout && timeout_response_option_i)) begin
         s_d.flag = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_q.unlock <= gwt_pkg::GWT_LOCKED;
         s_q.reload <= gwt_pkg::RELOAD_RST; // R8
         s_q.count <= gwt_pkg::RELOAD_RST;
         s_q.running <= 1'b0;
         s_q.exc_req <= 1'b0;
         s_q.rst_cnt <= gwt_pkg::RST_CNT_ZERO;
         s_q.flag <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reload_high_byte_o = s_q.count[15:8]; // R18
   assign reload_low_byte_o = s_q.count[7:0]; // R18
   assign reload_o = s_q.reload;
   assign running_o = s_q.running;
   assign exception_req_o = s_q.exc_req;
   assign device_reset_o = s_q.rst_cnt != gwt_pkg::RST_CNT_ZERO;
   assign reset_flag_o = s_q.flag;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_rst_pulse;
      device_reset_o [*4] ##1 !device_reset_o;
   endsequence

   property p_refresh_load;
      @(posedge core_clk_i) disable iff (srst_i)
      (refresh_i && s_q.running) |=> (s_q.count == $past(s_q.reload));
   endproperty
   a_refresh_load: assert property (p_refresh_load) else $error("refresh did not reload"); // R12

   property p_debug_quiet;
      @(posedge core_clk_i) disable iff (srst_i)
      (on_chip_debugger_i && s_q.running) |=> (!exception_req_o && !$rose(device_reset_o));
   endproperty
   a_debug_quiet: assert property (p_debug_quiet) else $error("timeout under debugger"); // R13

   property p_decrement;
      @(posedge core_clk_i) disable iff (srst_i)
      (s_q.running && tick && !load && s_q.count > gwt_pkg::CNT_ONE)
         |=> (s_q.count == $past(s_q.count) - gwt_pkg::CNT_ONE);
   endproperty
   a_decrement: assert property (p_decrement) else $error("counter did not decrement"); // R11

   property p_osc_off;
      @(posedge core_clk_i) disable iff (srst_i)
      (!guard_osc_enable_i && !load) |=> $stable(s_q.count);
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("counted with oscillator off"); // R5

   property p_exception;
      @(posedge core_clk_i) disable iff (srst_i)
      (timeout && !timeout_response_option_i)
         |=> (exception_req_o && s_q.count == $past(s_q.reload) && !device_reset_o);
   endproperty
   a_exception: assert property (p_exception) else $error("exception answer wrong"); // R15

   property p_reset_answer;
      @(posedge core_clk_i) disable iff (srst_i)
      (timeout && timeout_response_option_i && !reset_flag_clear_i)
         |=> (reset_flag_o && !exception_req_o) and s_rst_pulse;
   endproperty
   a_reset_answer: assert property (p_reset_answer) else $error("reset answer wrong"); // R16

   property p_enable;
      @(posedge core_clk_i) disable iff (srst_i)
      (!s_q.running && refresh_i) |=> running_o;
   endproperty
   a_enable: assert property (p_enable) else $error("refresh did not enable"); // R3

   property p_always_on;
      @(posedge core_clk_i) disable iff (srst_i)
      always_on_option_i [*2] |=> running_o;
   endproperty
   a_always_on: assert property (p_always_on) else $error("always-on not running"); // R4

   property p_first_load;
      @(posedge core_clk_i) disable iff (srst_i)
      $rose(s_q.running) |-> (s_q.count == $past(s_q.reload));
   endproperty
   a_first_load: assert property (p_first_load) else $error("first enable did not load"); // R10
endmodule : gwt_guard_timer
`default_nettype wire

// *** logic/gwt_pkg.sv ***
/*
 guard timer package: reset values, unlock bytes, pulse lengths, unlock states.
 assumes: included before every guard timer design file.
*/
`default_nettype none
package gwt_pkg;
   // ----------------------------------------
   // counter and reload
   // ----------------------------------------
   localparam logic [15:0] RELOAD_RST = 16'h0400;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CORE_CLK_HZ = 10_000_000;
   localparam int OSC_TYP_HZ = 10_000;
   // reload counts per millisecond of time-out at the typical rate
   localparam int RELOAD_PER_MS = OSC_TYP_HZ / 1000;
   // core cycles per typical oscillator period
   localparam int OSC_PERIOD_CYC = CORE_CLK_HZ / OSC_TYP_HZ;
   localparam logic [2:0] RST_PULSE_CYC = 3'h4;
   localparam logic [2:0] RST_CNT_ZERO = 3'h0;
   // ----------------------------------------
   // unlock sequence
   // ----------------------------------------
   localparam logic [7:0] UNLOCK_1 = 8'h55;
   localparam logic [7:0] UNLOCK_2 = 8'hAA;
   typedef enum logic [1:0] {
      GWT_LOCKED,
      GWT_GOT_FIRST,
      GWT_OPEN_HIGH,
      GWT_OPEN_LOW
   } gwt_unlock_t;
endpackage : gwt_pkg
`default_nettype wire

// *** logic/gwt_sync_rise.sv ***
/*
 two-flop synchroniser with rising edge detect for the oscillator pin.
 assumes: the pin is asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module gwt_sync_rise (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic async_i,
   output logic rise_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } gwt_sync_t;
   gwt_sync_t s_q;
   gwt_sync_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.meta = async_i;
      s_d.sync = s_q.meta;
      s_d.last = s_q.sync;
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         // reset high so a pin already high at release gives no false rise
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rise_o = s_q.sync & ~s_q.last;
endmodule : gwt_sync_rise
`default_nettype wire

// *** tb/gwt_rc_osc_model.sv ***
/*
 rc oscillator model: square wave with a fixed half period in core cycles.
 assumes: core_clk_i runs freely; run_i starts and stops the wave.
*/
`timescale 1ns/1ps
`default_nettype none
module gwt_rc_osc_model #(
   parameter int HALF = 5
) (
   input wire logic core_clk_i,
   input wire logic run_i,
   output logic rc_osc_o
);
   int cnt_q;
   initial rc_osc_o = 1'b0;
   // own wave, only sampled by the block through its synchroniser
   always @(posedge core_clk_i) begin
      if (run_i) begin // a stopped oscillator makes no edges
         cnt_q <= (cnt_q >= HALF - 1) ? 0 : cnt_q + 1;
         if (cnt_q >= HALF - 1) rc_osc_o <= ~rc_osc_o;
      end
   end
endmodule : gwt_rc_osc_model
`default_nettype wire

// *** tb/tb_gwt_guard_timer.sv ***
/*
 self-checking bench of the guard timer.
 assumes: design files and package compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_gwt_guard_timer;
   logic core_clk_i = 1'b0, srst_i = 1'b1, rc_osc_i, osc_en = 1'b1, ao = 1'b0, resp = 1'b0;
   logic dbg = 1'b0, refresh_i = 1'b0, wr_high_i = 1'b0, wr_low_i = 1'b0, clr = 1'b0;
   logic [7:0] wr_data_i = 8'h00, hi, lo;
   logic [15:0] reload_o, prev;
   logic running_o, exception_req_o, device_reset_o, reset_flag_o;
   wire logic [15:0] cnt = {hi, lo};
   int n_mismatch = 0, n_compared = 0, cycles = 0, steps, seen;
   always #50 core_clk_i = ~core_clk_i;
   gwt_rc_osc_model #(.HALF(5)) osc (.core_clk_i(core_clk_i), .run_i(1'b1), .rc_osc_o(rc_osc_i));
   gwt_guard_timer dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .rc_osc_i(rc_osc_i),
      .guard_osc_enable_i(osc_en), .always_on_option_i(ao), .timeout_response_option_i(resp),
      .on_chip_debugger_i(dbg), .refresh_i(refresh_i), .wr_high_i(wr_high_i),
      .wr_low_i(wr_low_i), .wr_data_i(wr_data_i), .reset_flag_clear_i(clr),
      .reload_high_byte_o(hi), .reload_low_byte_o(lo), .reload_o(reload_o),
      .running_o(running_o), .exception_req_o(exception_req_o),
      .device_reset_o(device_reset_o), .reset_flag_o(reset_flag_o));
   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask : cyc
   task automatic wr(input logic high, input logic [7:0] d);
      wr_high_i = high;
      wr_low_i = ~high;
      wr_data_i = d;
      cyc(1);
      wr_high_i = 1'b0;
      wr_low_i = 1'b0;
      cyc(1);
   endtask : wr
   task automatic kick();
      refresh_i = 1'b1;
      cyc(1);
      refresh_i = 1'b0;
      cyc(1);
   endtask : kick
   task automatic finish_test();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_start();
      `CHK(cnt, 16'h0400)
      `CHK(reload_o, 16'h0400)
      `CHK(running_o, 1'b0)
      kick();
      `CHK(running_o, 1'b1)
      `CHK(cnt, 16'h0400)
      for (int i = 0; i < 50 && cnt === 16'h0400; i++) cyc(1);
      `CHK(cnt, 16'h03FF)
      osc_en = 1'b0;
      prev = cnt;
      cyc(40);
      `CHK(cnt, prev)
      osc_en = 1'b1;
   endtask : t_start
   task automatic t_unlock();
      wr(1'b0, 8'h12);
      wr(1'b1, 8'h55);
      wr(1'b1, 8'h11);
      wr(1'b1, 8'h22);
      wr(1'b0, 8'h33);
      `CHK(reload_o, 16'h0400)
      wr(1'b1, 8'h55);
      wr(1'b1, 8'hAA);
      wr(1'b0, 8'h44);
      wr(1'b1, 8'hFF);
      wr(1'b0, 8'hFF);
      `CHK(reload_o, 16'hFFFF)
      wr(1'b1, 8'h55);
      wr(1'b1, 8'hAA);
      wr(1'b1, 8'h00);
      wr(1'b1, 8'h77);
      wr(1'b0, 8'h06);
      `CHK(reload_o, 16'h0006)
      kick();
      `CHK(cnt, 16'h0006)
   endtask : t_unlock
   task automatic t_exception();
      kick();
      prev = cnt;
      steps = 0;
      for (int i = 0; i < 300 && exception_req_o !== 1'b1; i++) begin
         cyc(1);
         if (exception_req_o !== 1'b1 && cnt !== prev) begin
            `CHK(cnt, prev - 16'h0001)
            steps++;
            prev = cnt;
         end
      end
      `CHK(exception_req_o, 1'b1)
      `CHK(steps, 5)
      `CHK(cnt, 16'h0006)
      `CHK(running_o, 1'b1)
      dbg = 1'b1;
      seen = 0;
      for (int i = 0; i < 200; i++) begin
         cyc(1);
         if (exception_req_o !== 1'b0) seen++;
      end
      `CHK(seen, 0)
      `CHK(cnt, 16'h0006)
      dbg = 1'b0;
   endtask : t_exception
   task automatic t_reset_mode();
      resp = 1'b1;
      kick();
      for (int i = 0; i < 300 && device_reset_o !== 1'b1; i++) cyc(1);
      steps = 0;
      for (int i = 0; i < 20 && device_reset_o === 1'b1; i++) begin
         steps++;
         cyc(1);
      end
      `CHK(steps, 4)
      `CHK(reset_flag_o, 1'b1)
      `CHK(reload_o, 16'h0400)
      `CHK(running_o, 1'b0)
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      `CHK(reset_flag_o, 1'b0)
      ao = 1'b1;
      srst_i = 1'b1;
      cyc(3);
      srst_i = 1'b0;
      cyc(2);
      `CHK(running_o, 1'b1)
   endtask : t_reset_mode
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      cyc(20);
      srst_i = 1'b0;
      cyc(1);
      t_start();
      t_unlock();
      t_exception();
      t_reset_mode();
      finish_test();
   end
endmodule : tb_gwt_guard_timer
`default_nettype wire
